// *** hdl/agw_defines.svh ***
`ifndef AGW_DEFINES_SVH
`define AGW_DEFINES_SVH

// -----------------------------------------------------------------------
// Configuration offsets (byte addresses within the function's space)
// -----------------------------------------------------------------------
`define AGW_OFF_STATUS 8'h1C
`define AGW_OFF_NPMEM 8'h20
`define AGW_OFF_PFMEM 8'h24
`define AGW_OFF_UPPER 8'h30
`define AGW_OFF_BRCTL 8'h3C

// -----------------------------------------------------------------------
// Status word field positions
// -----------------------------------------------------------------------
`define AGW_BIT_PARITY 31
`define AGW_BIT_SYSERR 30
`define AGW_BIT_MABORT 29
`define AGW_BIT_TABORT 28
`define AGW_BIT_TSENT 27
`define AGW_SEL_HI 26
`define AGW_SEL_LO 25
`define AGW_BIT_DPAR 24
`define AGW_BIT_QUICK 23
`define AGW_BIT_UDF 22
`define AGW_BIT_HISPD 21
`define AGW_BIT_CAPL 20
`define AGW_IOLIM_HI 15
`define AGW_IOLIM_LO 12
`define AGW_IOLIMR_HI 11
`define AGW_IOLIMR_LO 8
`define AGW_IOBASE_HI 7
`define AGW_IOBASE_LO 4
`define AGW_IOBASER_HI 3
`define AGW_IOBASER_LO 0

// -----------------------------------------------------------------------
// Window fields and fixed values
// -----------------------------------------------------------------------
`define AGW_TOP_HI 31
`define AGW_TOP_LO 20
`define AGW_BOT_HI 15
`define AGW_BOT_LO 4
`define AGW_ULIM_HI 23
`define AGW_ULIM_LO 16
`define AGW_UBASE_HI 7
`define AGW_UBASE_LO 0
`define AGW_SEL_MEDIUM 2'h1
`define AGW_IO32_CODE 4'h1
`define AGW_LOW12_ONES 12'hFFF
`define AGW_LOW12_ZERO 12'h000
`define AGW_LOW20_ONES 20'hFFFFF
`define AGW_LOW20_ZERO 20'h00000
`define AGW_CMD_IO 0
`define AGW_CMD_MEM 1

`endif

// *** hdl/agw_pkg.sv ***
// -----------------------------------------------------------------------
// Shared types for the graphics port window decode
// -----------------------------------------------------------------------
package agw_pkg;
    typedef logic [31:0] agw_word_t;   // Configuration data word
    typedef logic [11:0] agw_mb_t;     // Megabyte-granular address field
    typedef logic [7:0] agw_byte_t;    // Upper I/O address byte
    typedef logic [3:0] agw_nib_t;     // 4-Kbyte I/O address nibble
endpackage

// *** hdl/agw_io_match.sv ***
`include "agw_defines.svh"

// -----------------------------------------------------------------------
// I/O window comparator
// -----------------------------------------------------------------------
module agw_io_match
    import agw_pkg::*;
(
    input wire logic [31:0] addr,       // Host I/O address
    input wire agw_nib_t base_nib,      // Base address bits 15:12
    input wire agw_nib_t lim_nib,       // Limit address bits 15:12
    input wire agw_byte_t base_up,      // Base address bits 23:16
    input wire agw_byte_t lim_up,       // Limit address bits 23:16
    input wire logic up_en,             // Upper bytes take part in decode
    output logic hit                    // Address inside the window
);
    logic [23:0] lo_bound;              // Inclusive bottom
    logic [23:0] hi_bound;              // Inclusive top
    logic [23:0] a24;                   // Compared portion of address

    // Bounds at 4-Kbyte granularity; upper byte is zero when disabled
    always_comb begin
        lo_bound = {(up_en ? base_up : 8'h00), base_nib, `AGW_LOW12_ZERO};
        hi_bound = {(up_en ? lim_up : 8'h00), lim_nib, `AGW_LOW12_ONES};
        a24 = addr[23:0];
    end

    // Addresses above 24 bits never fall into this window
    assign hit = (addr[31:24] == 8'h00) && (a24 >= lo_bound) && (a24 <= hi_bound);
endmodule

// *** hdl/agw_mem_match.sv ***
`include "agw_defines.svh"

// -----------------------------------------------------------------------
// Megabyte-granular memory window comparator
// -----------------------------------------------------------------------
module agw_mem_match
    import agw_pkg::*;
(
    input wire logic [31:0] addr,       // Host memory address
    input wire agw_mb_t bottom,         // Window bottom, address bits 31:20
    input wire agw_mb_t top,            // Window top, address bits 31:20
    output logic hit                    // Address inside the window
);
    logic [31:0] lo_bound;              // Bottom with low bits zero
    logic [31:0] hi_bound;              // Top with low bits all ones

    // Implied low bits fill out each bound
    always_comb begin
        lo_bound = {bottom, `AGW_LOW20_ZERO};
        hi_bound = {top, `AGW_LOW20_ONES};
    end

    assign hit = (addr >= lo_bound) && (addr <= hi_bound);
endmodule

// *** hdl/agw_bridge.sv ***
`include "agw_defines.svh"

module agw_bridge
    import agw_pkg::*;
(
    input wire logic clock,              // Core clock, 100 MHz
    input wire logic rst,                // Asynchronous reset, active high
    input wire logic cfg_wr,             // Configuration write strobe
    input wire logic cfg_rd,             // Configuration read strobe
    input wire logic [7:0] cfg_addr,     // Configuration byte address
    input wire logic [3:0] cfg_be,       // Configuration byte enables
    input wire agw_word_t cfg_wdata,     // Configuration write data
    output agw_word_t cfg_rdata,         // Configuration read data
    output logic cfg_rvalid,             // Read data valid pulse
    input wire logic [1:0] cmd_enables,  // Command bits: 0 I/O, 1 memory
    input wire logic rd_err_dis,         // Host read-data-error-disable control
    input wire logic port_syserr,        // System error from graphics port
    input wire logic mst_abort,          // Own transaction ended in master abort
    input wire logic tgt_abort,          // Own transaction ended in target abort
    input wire logic mst_special,        // That transaction was a special cycle
    input wire logic host_valid,         // Host cycle presented for decode
    input wire logic host_is_io,         // Host cycle is I/O, else memory
    input wire logic [31:0] host_addr,   // Host cycle address
    output logic fwd_claim,              // Forward cycle to graphics port
    output logic fwd_prefetch,           // Claim came from prefetchable window
    output logic abort_as_error          // Master abort reported as error
);
    // -------------------------------------------------------------------
    // Stored configuration state
    // -------------------------------------------------------------------
    logic syserr_reg;                    // System error seen flag
    logic mabort_reg;                    // Master abort seen flag
    logic tabort_reg;                    // Target abort seen flag
    agw_nib_t io_lim_reg;                // I/O limit bits 15:12
    agw_nib_t io_base_reg;               // I/O base bits 15:12
    agw_mb_t np_top_reg;                 // Non-prefetchable top
    agw_mb_t np_bot_reg;                 // Non-prefetchable bottom
    agw_mb_t pf_top_reg;                 // Prefetchable top
    agw_mb_t pf_bot_reg;                 // Prefetchable bottom
    agw_byte_t up_lim_reg;               // I/O limit bits 23:16
    agw_byte_t up_base_reg;              // I/O base bits 23:16
    agw_word_t rdata_reg;                // Registered read data
    logic rvalid_reg;                    // Registered read valid
    logic claim_reg;                     // Registered forward decision
    logic pref_reg;                      // Registered prefetch indication
    logic aerr_reg;                      // Registered abort response

    // Write hit decode per register
    logic wr_status;                     // Status word written
    logic wr_np;                         // Non-prefetchable window written
    logic wr_pf;                         // Prefetchable window written
    logic wr_up;                         // Upper I/O bytes written

    // Comparator results
    logic io_hit;                        // Inside I/O window
    logic np_hit;                        // Inside non-prefetchable window
    logic pf_hit;                        // Inside prefetchable window
    logic up_en;                         // Extended I/O decode active

    // Event qualifying: special cycles never set the abort flags
    logic mabort_evt;                    // Qualified master abort
    logic tabort_evt;                    // Qualified target abort

    // Returns the write-one-to-clear outcome with set taking priority
    function automatic logic w1c_next(input logic cur, input logic set,
                                      input logic clr);
        w1c_next = set | (cur & ~clr);
    endfunction

    // Builds one window word: top in 31:20, bottom in 15:4
    function automatic agw_word_t win_word(input agw_mb_t top, input agw_mb_t bot);
        agw_word_t w;
        w = '0;
        w[`AGW_TOP_HI:`AGW_TOP_LO] = top;
        w[`AGW_BOT_HI:`AGW_BOT_LO] = bot;
        win_word = w;
    endfunction

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    assign wr_status = cfg_wr && (cfg_addr == `AGW_OFF_STATUS);
    assign wr_np = cfg_wr && (cfg_addr == `AGW_OFF_NPMEM);
    assign wr_pf = cfg_wr && (cfg_addr == `AGW_OFF_PFMEM);
    assign wr_up = cfg_wr && (cfg_addr == `AGW_OFF_UPPER);

    assign mabort_evt = mst_abort && !mst_special;
    assign tabort_evt = tgt_abort && !mst_special;

    // -------------------------------------------------------------------
    // Sticky error flags
    // -------------------------------------------------------------------
    // An event in the clearing cycle survives, so no error is lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syserr_reg <= 1'b0;
            mabort_reg <= 1'b0;
            tabort_reg <= 1'b0;
        end else begin
            syserr_reg <= w1c_next(syserr_reg, port_syserr,
                                   wr_status && cfg_be[3] && cfg_wdata[`AGW_BIT_SYSERR]);
            mabort_reg <= w1c_next(mabort_reg, mabort_evt,
                                   wr_status && cfg_be[3] && cfg_wdata[`AGW_BIT_MABORT]);
            tabort_reg <= w1c_next(tabort_reg, tabort_evt,
                                   wr_status && cfg_be[3] && cfg_wdata[`AGW_BIT_TABORT]);
        end
    end

    // -------------------------------------------------------------------
    // 16-bit I/O base and limit nibbles
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            io_lim_reg <= '0;
            io_base_reg <= '0;
        end else begin
            if (wr_status && cfg_be[1]) begin
                io_lim_reg <= cfg_wdata[`AGW_IOLIM_HI:`AGW_IOLIM_LO];
            end
            if (wr_status && cfg_be[0]) begin
                io_base_reg <= cfg_wdata[`AGW_IOBASE_HI:`AGW_IOBASE_LO];
            end
        end
    end

    // -------------------------------------------------------------------
    // Memory windows
    // -------------------------------------------------------------------
    // Fields straddle byte lanes, so a field updates when both its lanes write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            np_top_reg <= '0;
            np_bot_reg <= '0;
            pf_top_reg <= '0;
            pf_bot_reg <= '0;
        end else begin
            if (wr_np && cfg_be[3] && cfg_be[2]) begin
                np_top_reg <= cfg_wdata[`AGW_TOP_HI:`AGW_TOP_LO];
            end
            if (wr_np && cfg_be[1] && cfg_be[0]) begin
                np_bot_reg <= cfg_wdata[`AGW_BOT_HI:`AGW_BOT_LO];
            end
            if (wr_pf && cfg_be[3] && cfg_be[2]) begin
                pf_top_reg <= cfg_wdata[`AGW_TOP_HI:`AGW_TOP_LO];
            end
            if (wr_pf && cfg_be[1] && cfg_be[0]) begin
                pf_bot_reg <= cfg_wdata[`AGW_BOT_HI:`AGW_BOT_LO];
            end
        end
    end

    // -------------------------------------------------------------------
    // Upper I/O address bytes
    // -------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            up_lim_reg <= '0;
            up_base_reg <= '0;
        end else begin
            if (wr_up && cfg_be[2]) begin
                up_lim_reg <= cfg_wdata[`AGW_ULIM_HI:`AGW_ULIM_LO];
            end
            if (wr_up && cfg_be[0]) begin
                up_base_reg <= cfg_wdata[`AGW_UBASE_HI:`AGW_UBASE_LO];
            end
        end
    end

    // Whole register zero means only the 16-bit window decodes
    assign up_en = (up_lim_reg != 8'h00) || (up_base_reg != 8'h00);

    // -------------------------------------------------------------------
    // Read data path
    // -------------------------------------------------------------------
    // Constant fields are assembled here; unmapped offsets return zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cfg_rd;
            if (cfg_rd) begin
                rdata_reg <= '0;
                case (cfg_addr)
                    `AGW_OFF_STATUS: begin
                        rdata_reg[`AGW_BIT_SYSERR] <= syserr_reg;
                        rdata_reg[`AGW_BIT_MABORT] <= mabort_reg;
                        rdata_reg[`AGW_BIT_TABORT] <= tabort_reg;
                        rdata_reg[`AGW_SEL_HI:`AGW_SEL_LO] <= `AGW_SEL_MEDIUM;
                        rdata_reg[`AGW_BIT_HISPD] <= 1'b1;
                        rdata_reg[`AGW_IOLIM_HI:`AGW_IOLIM_LO] <= io_lim_reg;
                        rdata_reg[`AGW_IOLIMR_HI:`AGW_IOLIMR_LO] <= `AGW_IO32_CODE;
                        rdata_reg[`AGW_IOBASE_HI:`AGW_IOBASE_LO] <= io_base_reg;
                        rdata_reg[`AGW_IOBASER_HI:`AGW_IOBASER_LO] <= `AGW_IO32_CODE;
                    end
                    `AGW_OFF_NPMEM: begin
                        rdata_reg <= win_word(np_top_reg, np_bot_reg);
                    end
                    `AGW_OFF_PFMEM: begin
                        rdata_reg <= win_word(pf_top_reg, pf_bot_reg);
                    end
                    `AGW_OFF_UPPER: begin
                        rdata_reg[`AGW_ULIM_HI:`AGW_ULIM_LO] <= up_lim_reg;
                        rdata_reg[`AGW_UBASE_HI:`AGW_UBASE_LO] <= up_base_reg;
                    end
                    `AGW_OFF_BRCTL: begin
                        // Bridge control fixed bits read zero
                        rdata_reg <= '0;
                    end
                    default: begin
                        rdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cfg_rvalid = rvalid_reg;

    // -------------------------------------------------------------------
    // Window comparators
    // -------------------------------------------------------------------
    agw_io_match u_io (
        .addr(host_addr),
        .base_nib(io_base_reg),
        .lim_nib(io_lim_reg),
        .base_up(up_base_reg),
        .lim_up(up_lim_reg),
        .up_en(up_en),
        .hit(io_hit)
    );

    agw_mem_match u_np (
        .addr(host_addr),
        .bottom(np_bot_reg),
        .top(np_top_reg),
        .hit(np_hit)
    );

    agw_mem_match u_pf (
        .addr(host_addr),
        .bottom(pf_bot_reg),
        .top(pf_top_reg),
        .hit(pf_hit)
    );

    // -------------------------------------------------------------------
    // Forwarding decision
    // -------------------------------------------------------------------
    // Registered so the claim is stable for one cycle after the request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            claim_reg <= 1'b0;
            pref_reg <= 1'b0;
        end else begin
            claim_reg <= 1'b0;
            pref_reg <= 1'b0;
            if (host_valid && host_is_io) begin
                claim_reg <= io_hit && cmd_enables[`AGW_CMD_IO];
            end else if (host_valid) begin
                claim_reg <= (np_hit || pf_hit) && cmd_enables[`AGW_CMD_MEM];
                pref_reg <= pf_hit && !np_hit && cmd_enables[`AGW_CMD_MEM];
            end
        end
    end

    // Abort handling follows the host control, not a local mode bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aerr_reg <= 1'b0;
        end else begin
            aerr_reg <= !rd_err_dis;
        end
    end

    assign fwd_claim = claim_reg;
    assign fwd_prefetch = pref_reg;
    assign abort_as_error = aerr_reg;
endmodule

// *** verification/agw_bridge_sva.sv ***
// ------------------------------------------
// Port checks for the window decode bridge
// ------------------------------------------
module agw_bridge_sva
    import agw_pkg::*;
(
    input wire logic clock, // Core clock
    input wire logic rst, // Async reset
    input wire logic cfg_rd, // Read strobe
    input wire logic [7:0] cfg_addr, // Byte address
    input wire agw_word_t cfg_rdata, // Read data
    input wire logic cfg_rvalid, // Read valid
    input wire logic [1:0] cmd_enables, // Forward enables
    input wire logic rd_err_dis, // Error disable
    input wire logic port_syserr, // Port error
    input wire logic mst_abort, // Master abort
    input wire logic tgt_abort, // Target abort
    input wire logic mst_special, // Special cycle
    input wire logic host_valid, // Host cycle
    input wire logic host_is_io, // I/O cycle
    input wire logic [31:0] host_addr, // Host address
    input wire logic fwd_claim, // Claim
    input wire logic fwd_prefetch, // Prefetch claim
    input wire logic abort_as_error // Abort mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_read_answer: assert property (cfg_rd |=> cfg_rvalid ##1 !cfg_rvalid || cfg_rd)
        else $error("read answer wrong");
    a_status_fixed: assert property (cfg_rd && cfg_addr == 8'h1C |=>
        (cfg_rdata & 32'h8FF00F0F) == 32'h02200101) else $error("status fixed bits wrong");
    a_ctl_zero: assert property (cfg_rd && cfg_addr == 8'h3C |=> cfg_rdata[23:21] == 3'h0)
        else $error("bridge control bits set");
    a_syserr_sets: assert property (port_syserr ##1 cfg_rd && cfg_addr == 8'h1C |=> cfg_rdata[30])
        else $error("system error flag not set");
    a_mabort_sets: assert property (mst_abort && !mst_special ##1 cfg_rd && cfg_addr == 8'h1C
        |=> cfg_rdata[29]) else $error("master abort flag not set");
    a_tabort_sets: assert property (tgt_abort && !mst_special ##1 cfg_rd && cfg_addr == 8'h1C
        |=> cfg_rdata[28]) else $error("target abort flag not set");
    a_io_enable: assert property (host_valid && host_is_io && !cmd_enables[0] |=> !fwd_claim)
        else $error("I/O claimed while disabled");
    a_mem_enable: assert property (host_valid && !host_is_io && !cmd_enables[1] |=> !fwd_claim)
        else $error("memory claimed while disabled");
    a_io_upper: assert property (host_valid && host_is_io && host_addr[31:24] != 8'h00
        |=> !fwd_claim) else $error("I/O claim above 24 bits");
    a_claim_cause: assert property (fwd_prefetch |-> fwd_claim && $past(host_valid))
        else $error("claim without host cycle");
    a_abort_mode: assert property (1'b1 |=> abort_as_error == !$past(rd_err_dis))
        else $error("abort mode not following control");
endmodule

bind agw_bridge agw_bridge_sva u_sva (.clock, .rst, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rvalid,
    .cmd_enables, .rd_err_dis, .port_syserr, .mst_abort, .tgt_abort, .mst_special, .host_valid,
    .host_is_io, .host_addr, .fwd_claim, .fwd_prefetch, .abort_as_error);

// *** verification/agw_far_model.sv ***
// ------------------------------------------
// Host bus and graphics target stand-in
// ------------------------------------------
module agw_far_model
    import agw_pkg::*;
(
    input wire logic clock, // Core clock
    output logic port_syserr, // Error from graphics port
    output logic mst_abort, // Master abort end
    output logic tgt_abort, // Target abort end
    output logic mst_special, // Special cycle qualifier
    output logic host_valid, // Host cycle valid
    output logic host_is_io, // Host cycle is I/O
    output logic [31:0] host_addr // Host address
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet start; address idles on a changing pattern, never a stale copy
    initial begin
        {port_syserr, mst_abort, tgt_abort, mst_special, host_valid, host_is_io} = 6'h00;
        host_addr = 32'hA5A5A5A5;
    end
    // One-cycle event: 0 port error, 1 master abort, 2 target abort
    task automatic pulse_event(input int kind, input logic special);
        @(negedge clock);
        port_syserr = (kind == 0);
        mst_abort = (kind == 1);
        tgt_abort = (kind == 2);
        mst_special = special;
        @(negedge clock);
        {port_syserr, mst_abort, tgt_abort} = 3'h0;
        mst_special = ~special;
    endtask
    // One host cycle presented for decode
    task automatic host(input logic io, input logic [31:0] a);
        @(negedge clock);
        host_valid = 1'b1;
        host_is_io = io;
        host_addr = a;
        @(negedge clock);
        host_valid = 1'b0;
        host_addr = ~a;
    endtask
endmodule

// *** verification/tb_top.sv ***
module tb_top
    import agw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------
    // Stimulus, expectation queues and monitor
    // ------------------------------------------
    logic clock, rst, cfg_wr, cfg_rd, rd_err_dis, cfg_rvalid, hv;
    logic port_syserr, mst_abort, tgt_abort, mst_special, host_valid, host_is_io;
    logic fwd_claim, fwd_prefetch, abort_as_error;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [1:0] cmd_enables;
    logic [31:0] host_addr;
    agw_word_t cfg_wdata, cfg_rdata, d, st;
    agw_word_t rd_q[$]; // Expected read data, oldest first
    logic [1:0] dec_q[$]; // Expected {claim, prefetch}
    int miscompares = 0;
    int checks = 0;
    localparam logic [7:0] addrs [6] = '{8'h1C, 8'h20, 8'h24, 8'h30, 8'h3C, 8'h40};
    localparam agw_word_t wmask [6] = '{32'h0000F0F0, 32'hFFF0FFF0, 32'hFFF0FFF0,
        32'h00FF00FF, 32'h0, 32'h0};
    localparam logic [31:0] maddr [8] = '{32'h0FFFFFFF, 32'h10000000, 32'h1FFFFFFF,
        32'h20000000, 32'h2FFFFFFF, 32'h30000000, 32'h30FFFFFF, 32'h31000000};
    localparam logic [1:0] mexp [8] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0};

    agw_bridge dut (.clock, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
        .cfg_rvalid, .cmd_enables, .rd_err_dis, .port_syserr, .mst_abort, .tgt_abort,
        .mst_special, .host_valid, .host_is_io, .host_addr, .fwd_claim, .fwd_prefetch,
        .abort_as_error);
    agw_far_model far (.clock, .port_syserr, .mst_abort, .tgt_abort, .mst_special,
        .host_valid, .host_is_io, .host_addr);

    task automatic check(input agw_word_t seen, input agw_word_t exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input agw_word_t v);
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = v;
        @(negedge clock);
        cfg_wr = 1'b0;
        cfg_wdata = ~v;
    endtask
    task automatic rd(input logic [7:0] a, input agw_word_t exp);
        rd_q.push_back(exp);
        @(negedge clock);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clock);
        cfg_rd = 1'b0;
    endtask
    // Note the decode outcome first, then let the far side present the cycle
    task automatic hc(input logic io, input logic [31:0] a, input logic [1:0] exp);
        dec_q.push_back(exp);
        far.host(io, a);
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Sample after the edge so registered results have landed
    always begin
        @(posedge clock);
        hv = host_valid;
        #1;
        if (cfg_rvalid === 1'b1) check(cfg_rdata, rd_q.pop_front());
        if (hv === 1'b1) check({30'h0, fwd_claim, fwd_prefetch}, {30'h0, dec_q.pop_front()});
    end
    // Cut a hang short; the whole run needs only about 120 cycles
    initial begin
        #100us;
        miscompares++;
        report_and_stop();
    end

    initial begin
        {rst, cfg_wr, cfg_rd, rd_err_dis, cfg_be, cfg_addr, cmd_enables} = 18'h20000;
        cfg_wdata = 32'h0;
        d = $urandom(32'h24d1f2ca);
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        // Reset values, then random writes filtered by each field's access
        foreach (addrs[i]) rd(addrs[i], (i == 0) ? 32'h02200101 : 32'h0);
        foreach (addrs[i]) begin
            d = $urandom;
            st = (d & wmask[i]) | ((i == 0) ? 32'h02200101 : 32'h0);
            wr(addrs[i], 4'hF, d);
            rd(addrs[i], st);
        end
        st = (st & 32'h0) | 32'h02200101 | ((d & wmask[0]) & 32'h0);
        wr(8'h1C, 4'hF, 32'h0000F0F0);
        st = 32'h0220F1F1;
        $display("test registers done");
        // Each flag sets on its event and clears only by writing one
        for (int k = 0; k < 3; k++) begin
            far.pulse_event(k, 1'b0);
            rd(8'h1C, st | (32'h40000000 >> k));
            wr(8'h1C, 4'h8, 32'h40000000 >> k);
            rd(8'h1C, st);
        end
        far.pulse_event(1, 1'b1);
        far.pulse_event(2, 1'b1);
        rd(8'h1C, st);
        $display("test flags done");
        // Both megabyte windows, edges included, then memory forwarding off
        wr(8'h20, 4'hF, 32'h1FF01000);
        wr(8'h24, 4'hF, 32'h30F03000);
        cmd_enables = 2'b10;
        foreach (maddr[i]) begin
            rd_err_dis = d[i];
            hc(1'b0, maddr[i], mexp[i]);
        end
        cmd_enables = 2'b01;
        hc(1'b0, 32'h10000000, 2'h0);
        $display("test memory done");
        // 4-Kbyte I/O window, 16-bit then extended to 24 bits
        wr(8'h30, 4'hF, 32'h0);
        wr(8'h1C, 4'h3, 32'h00003020);
        hc(1'b1, 32'h00001FFF, 2'h0);
        hc(1'b1, 32'h00002000, 2'h2);
        hc(1'b1, 32'h00003FFF, 2'h2);
        hc(1'b1, 32'h00004000, 2'h0);
        hc(1'b1, 32'h01002000, 2'h0);
        wr(8'h30, 4'h5, 32'h00010001);
        hc(1'b1, 32'h00012000, 2'h2);
        hc(1'b1, 32'h00013FFF, 2'h2);
        hc(1'b1, 32'h00002000, 2'h0);
        hc(1'b1, 32'h00014000, 2'h0);
        cmd_enables = 2'b10;
        hc(1'b1, 32'h00012000, 2'h0);
        $display("test io done");
        repeat (4) @(negedge clock);
        check({30'h0, rd_q.size() == 0, dec_q.size() == 0}, 32'h3);
        report_and_stop();
    end
endmodule
